// >>> src/mpt_top.sv
// Purpose: Pattern transfer trigger select with fault shutdown and input filters
// Assumes: Reload timer and PPG run on clk_i; sensor and fault pins are asynchronous
// Notes: Registers on classic Wishbone, one word each
// Contract
// - Mode 011 full position match starts timer
// - Mode 011 transfers only on started timer underflow
// - Mode 100 transfers on match or underflow
// - Mode 110 ignores detections after the first
// - Mode 111 accepts only first detection
// - Mode 101 recognises only first detection
// - Shutdown acts only on enabled phase outputs
// - Enabled low fault forces latch levels out
// - Disabled or high fault leaves outputs alone
// - Accepted enabled fault raises interrupt flag
// - Transfers and detection continue during shutdown
// - Shutdown active one to two cycles later
// - Fault filter delays by 4 to 32
// - Position filter delays by 4 to 32
// - Filtered inputs invalid while oscillator stopped
// - Separate programmable lengths reject short pulses
// - Fault accepted when level outlasts counter
// - Flag clears on 0, RMW reads 1
`timescale 1ns/1ps
`include "mpt_map.svh"
module mpt_top #(
   parameter int N_PHASE = 6,
   parameter int N_POS = 3,
   parameter int N_BUF = 8,
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_lock_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic [N_POS-1:0] position_sense_in_i,
   input wire logic fault_shutdown_in_i,
   input wire logic reload_timer_pulse_out_i,
   input wire logic ppg_i,
   input wire logic osc_stop_i,
   output logic timer_start_o,
   output logic [N_PHASE-1:0] motor_phase_out_o,
   output logic fault_irq_o,
   output logic shutdown_active_o
);
   localparam int PW = 2 * N_PHASE; // Two code bits per phase
   localparam int CFGW = $bits(mpt_pkg::mpt_cfg_t); // Control group width
   // Bus and software state
   logic ack_r, ack_nxt; // Wishbone acknowledge
   logic [31:0] dat_r, dat_nxt; // Read data
   mpt_pkg::mpt_cfg_t cfg_r, cfg_nxt; // Control fields
   logic flag_r, flag_nxt; // Fault interrupt flag
   logic [N_PHASE-1:0] oe_r, oe_nxt; // Phase output enables
   logic [N_PHASE-1:0] latch_r, latch_nxt; // Port data latch
   logic [PW-1:0] buf_r [N_BUF]; // Pattern buffers
   logic [PW-1:0] buf_nxt [N_BUF];
   // Trigger and output state
   mpt_pkg::mpt_trg_t trg_r, trg_nxt;
   logic [PW-1:0] active_r, active_nxt; // Active pattern
   logic start_r, start_nxt;
   logic [N_PHASE-1:0] out_r, out_nxt;
   logic sd_r, sd_nxt; // Shutdown active
   logic fault_d_r, fault_d_nxt; // Previous accepted fault
   logic [N_POS-1:0] pos_d_r, pos_d_nxt; // Previous filtered position
   logic tin_d_r, tin_d_nxt; // Previous timer pulse level
   // Combinational helpers
   logic [N_POS-1:0] pos_sync, pos_filt;
   logic fault_sync, fault_filt;
   logic pos_valid, fault_ok, fault_rise, match, match_ok, uf, xfer, buf0_wr, mode_chg;
   logic wr_now, os_mode;
   logic [2:0] buf_idx;
   logic [AW-1:0] adr;
   logic [31:0] ctrl_word, port_word, wdata;
   logic [1:0] pat_pair;

   mpt_sync #(.W(N_POS), .RST_VAL('0)) u_pos_sync (
      .clk_i(clk_i), .rst_i(rst_i), .d_i(position_sense_in_i), .q_o(pos_sync));
   mpt_sync #(.W(1), .RST_VAL(1'b1)) u_flt_sync (
      .clk_i(clk_i), .rst_i(rst_i), .d_i(fault_shutdown_in_i), .q_o(fault_sync));
   mpt_filter #(.W(N_POS), .CW(5), .RST_VAL('0)) u_pos_filt (
      .clk_i(clk_i), .rst_i(rst_i), .in_i(pos_sync),
      .en_i(cfg_r.position_filter_enable), .len_i(cfg_r.pos_len), .out_o(pos_filt));
   mpt_filter #(.W(1), .CW(5), .RST_VAL(1'b1)) u_flt_filt (
      .clk_i(clk_i), .rst_i(rst_i), .in_i(fault_sync),
      .en_i(cfg_r.shutdown_filter_enable), .len_i(cfg_r.sd_len), .out_o(fault_filt));

   // Byte-lane merge for writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         old_v[8*b +: 8] = sel[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
      end
      lane_merge = old_v;
   endfunction

   // Phase level from a code pair: 00 low, 01 PPG, 1x high
   function automatic logic phase_level(input logic [1:0] code, input logic ppg);
      phase_level = code[1] | (code[0] & ppg);
   endfunction

   // Register words as seen by software
   always_comb begin
      ctrl_word = 32'h0;
      ctrl_word[`MPT_CTRL_MODE_LSB +: 3] = cfg_r.transfer_trigger_select;
      ctrl_word[`MPT_CTRL_SDEN_BIT] = cfg_r.shutdown_enable;
      ctrl_word[`MPT_CTRL_SDFILT_BIT] = cfg_r.shutdown_filter_enable;
      ctrl_word[`MPT_CTRL_SDLEN_LSB +: 2] = cfg_r.sd_len;
      ctrl_word[`MPT_CTRL_FLAG_BIT] = flag_r;
      ctrl_word[`MPT_CTRL_CODE_LSB +: 3] = cfg_r.expected_position_code;
      ctrl_word[`MPT_CTRL_POSFILT_LSB +: 3] = cfg_r.position_filter_enable;
      ctrl_word[`MPT_CTRL_POSLEN_LSB +: 2] = cfg_r.pos_len;
      port_word = 32'h0;
      port_word[`MPT_PORT_OE_LSB +: N_PHASE] = oe_r;
      port_word[`MPT_PORT_LATCH_LSB +: N_PHASE] = latch_r;
   end

   // Trigger event decode
   always_comb begin
      adr = wb_adr_i;
      // A write lands on the edge where the master sees ack
      wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
      buf0_wr = wr_now && adr[AW-1:5] == (AW-5)'(`MPT_BUF_BASE_HI) && adr[4:2] == 3'h0
                && (&wb_sel_i);
      mode_chg = wr_now && adr == `MPT_OFF_CTRL && wb_sel_i[0]
                 && wb_dat_i[`MPT_CTRL_MODE_LSB +: 3] != cfg_r.transfer_trigger_select;
      // Filtered inputs dead while oscillator stopped
      pos_valid = ~(osc_stop_i & (|cfg_r.position_filter_enable));
      fault_ok = ~fault_filt & ~(osc_stop_i & cfg_r.shutdown_filter_enable);
      fault_rise = fault_ok & ~fault_d_r;
      match = pos_valid && pos_filt != pos_d_r && pos_filt == cfg_r.expected_position_code;
      // Underflow seen as rising edge of long timer pulse
      uf = reload_timer_pulse_out_i & ~tin_d_r;
      os_mode = cfg_r.transfer_trigger_select inside {mpt_pkg::MODE_OS_POS_OR_UF,
                                                     mpt_pkg::MODE_OS_POS,
                                                     mpt_pkg::MODE_OS_POS_AND_UF};
      match_ok = match & ~(os_mode & trg_r != mpt_pkg::TRG_IDLE);
      buf_idx = cfg_r.expected_position_code;
      xfer = 1'b0;
      start_nxt = 1'b0;
      trg_nxt = trg_r;
      unique case (cfg_r.transfer_trigger_select)
         mpt_pkg::MODE_WRITE: begin
            xfer = buf0_wr;
            buf_idx = 3'h0;
         end
         mpt_pkg::MODE_UNDERFLOW: xfer = uf;
         mpt_pkg::MODE_POS: xfer = match_ok;
         mpt_pkg::MODE_OS_POS: begin
            xfer = match_ok;
            if (match_ok) trg_nxt = mpt_pkg::TRG_DONE;
         end
         mpt_pkg::MODE_POS_OR_UF: xfer = match_ok | uf;
         mpt_pkg::MODE_OS_POS_OR_UF: begin
            xfer = match_ok | uf;
            if (match_ok) trg_nxt = mpt_pkg::TRG_DONE;
         end
         // Match starts the one-shot timer, underflow transfers
         mpt_pkg::MODE_POS_AND_UF, mpt_pkg::MODE_OS_POS_AND_UF: begin
            start_nxt = match_ok;
            xfer = uf & (trg_r == mpt_pkg::TRG_WAIT_UF);
            if (match_ok) begin
               trg_nxt = mpt_pkg::TRG_WAIT_UF;
            end else if (xfer) begin
               trg_nxt = os_mode ? mpt_pkg::TRG_DONE : mpt_pkg::TRG_IDLE;
            end
         end
      endcase
      // New mode restarts the one-shot sequence
      if (mode_chg) trg_nxt = mpt_pkg::TRG_IDLE;
   end

   // Pattern, shutdown and pin drive
   always_comb begin
      active_nxt = xfer ? buf_r[buf_idx] : active_r;
      // Mode 000 takes the word being written, not the stale buffer
      if (xfer && cfg_r.transfer_trigger_select == mpt_pkg::MODE_WRITE) begin
         active_nxt = wb_dat_i[PW-1:0];
      end
      // Shutdown one cycle after accepted fault
      sd_nxt = cfg_r.shutdown_enable & fault_ok;
      fault_d_nxt = fault_ok;
      pos_d_nxt = pos_valid ? pos_filt : pos_d_r;
      tin_d_nxt = reload_timer_pulse_out_i;
      for (int i = 0; i < N_PHASE; i++) begin
         pat_pair = active_r[2*i +: 2];
         // Only enabled phases take the pattern or the shutdown
         if (!oe_r[i] || sd_r) begin
            out_nxt[i] = latch_r[i];
         end else begin
            out_nxt[i] = phase_level(pat_pair, ppg_i);
         end
      end
      if (N_PHASE == 0) pat_pair = 2'b00;
   end

   // Register bus slave
   always_comb begin
      ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
      dat_nxt = 32'h0;
      cfg_nxt = cfg_r;
      oe_nxt = oe_r;
      latch_nxt = latch_r;
      for (int k = 0; k < N_BUF; k++) buf_nxt[k] = buf_r[k];
      wdata = 32'h0;
      if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
         if (adr == `MPT_OFF_CTRL) begin
            dat_nxt = ctrl_word;
            // Locked read-modify-write sees flag as 1
            if (wb_lock_i) dat_nxt[`MPT_CTRL_FLAG_BIT] = 1'b1;
         end else if (adr == `MPT_OFF_PORT) begin
            dat_nxt = port_word;
         end else if (adr == `MPT_OFF_ACTIVE) begin
            dat_nxt = {{(32-PW){1'b0}}, active_r};
         end else if (adr == `MPT_OFF_STATUS) begin
            dat_nxt[`MPT_STAT_POS_LSB +: N_POS] = pos_filt;
            dat_nxt[`MPT_STAT_SD_BIT] = sd_r;
            dat_nxt[`MPT_STAT_TRG_LSB +: 2] = trg_r;
            dat_nxt[`MPT_STAT_FAULT_BIT] = fault_ok;
         end else if (adr[AW-1:5] == (AW-5)'(`MPT_BUF_BASE_HI)) begin
            dat_nxt = {{(32-PW){1'b0}}, buf_r[adr[4:2]]};
         end
      end
      if (wr_now && adr == `MPT_OFF_CTRL) begin
         wdata = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
         cfg_nxt.transfer_trigger_select =
            mpt_pkg::mpt_mode_t'(wdata[`MPT_CTRL_MODE_LSB +: 3]);
         cfg_nxt.shutdown_enable = wdata[`MPT_CTRL_SDEN_BIT];
         cfg_nxt.shutdown_filter_enable = wdata[`MPT_CTRL_SDFILT_BIT];
         cfg_nxt.sd_len = wdata[`MPT_CTRL_SDLEN_LSB +: 2];
         cfg_nxt.expected_position_code = wdata[`MPT_CTRL_CODE_LSB +: 3];
         cfg_nxt.position_filter_enable = wdata[`MPT_CTRL_POSFILT_LSB +: 3];
         cfg_nxt.pos_len = wdata[`MPT_CTRL_POSLEN_LSB +: 2];
      end else if (wr_now && adr == `MPT_OFF_PORT) begin
         wdata = lane_merge(port_word, wb_dat_i, wb_sel_i);
         oe_nxt = wdata[`MPT_PORT_OE_LSB +: N_PHASE];
         latch_nxt = wdata[`MPT_PORT_LATCH_LSB +: N_PHASE];
      end else if (wr_now && adr[AW-1:5] == (AW-5)'(`MPT_BUF_BASE_HI)) begin
         wdata = lane_merge({{(32-PW){1'b0}}, buf_r[adr[4:2]]}, wb_dat_i, wb_sel_i);
         buf_nxt[adr[4:2]] = wdata[PW-1:0];
      end
      // Set beats a software clear of the flag
      flag_nxt = flag_r;
      if (wr_now && adr == `MPT_OFF_CTRL && wb_sel_i[0] && !wb_dat_i[`MPT_CTRL_FLAG_BIT]) begin
         flag_nxt = 1'b0;
      end
      if (cfg_r.shutdown_enable && fault_rise) flag_nxt = 1'b1;
   end

   // Register every group
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
         cfg_r <= mpt_pkg::mpt_cfg_t'(CFGW'(`MPT_RST_CTRL));
         flag_r <= 1'b0;
         oe_r <= '0;
         latch_r <= '0;
         for (int k = 0; k < N_BUF; k++) buf_r[k] <= `MPT_RST_PATTERN;
         trg_r <= mpt_pkg::TRG_IDLE;
         active_r <= `MPT_RST_PATTERN;
         start_r <= 1'b0;
         out_r <= '0;
         sd_r <= 1'b0;
         fault_d_r <= 1'b0;
         pos_d_r <= '0;
         tin_d_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         cfg_r <= cfg_nxt;
         flag_r <= flag_nxt;
         oe_r <= oe_nxt;
         latch_r <= latch_nxt;
         for (int k = 0; k < N_BUF; k++) buf_r[k] <= buf_nxt[k];
         trg_r <= trg_nxt;
         active_r <= active_nxt;
         start_r <= start_nxt;
         out_r <= out_nxt;
         sd_r <= sd_nxt;
         fault_d_r <= fault_d_nxt;
         pos_d_r <= pos_d_nxt;
         tin_d_r <= tin_d_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign timer_start_o = start_r;
   assign motor_phase_out_o = out_r;
   assign fault_irq_o = flag_r;
   assign shutdown_active_o = sd_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_start;
      cfg_r.transfer_trigger_select == mpt_pkg::MODE_POS_AND_UF && match |=> timer_start_o;
   endproperty
   a_start: assert property (p_start) else $error("match did not start timer");
   property p_uf_only;
      cfg_r.transfer_trigger_select == mpt_pkg::MODE_POS_AND_UF && !uf |=> $stable(active_r);
   endproperty
   a_uf_only: assert property (p_uf_only) else $error("transfer without underflow");
   property p_or;
      cfg_r.transfer_trigger_select == mpt_pkg::MODE_POS_OR_UF && (match || uf)
         |=> active_r == $past(buf_r[cfg_r.expected_position_code]);
   endproperty
   a_or: assert property (p_or) else $error("or mode missed transfer");
   property p_os_pos;
      cfg_r.transfer_trigger_select == mpt_pkg::MODE_OS_POS && trg_r == mpt_pkg::TRG_DONE
         && !mode_chg |=> $stable(active_r);
   endproperty
   a_os_pos: assert property (p_os_pos) else $error("one-shot took second match");
   property p_os_and;
      cfg_r.transfer_trigger_select == mpt_pkg::MODE_OS_POS_AND_UF
         && trg_r != mpt_pkg::TRG_IDLE |=> !timer_start_o;
   endproperty
   a_os_and: assert property (p_os_and) else $error("one-shot restarted timer");
   property p_oe_off;
      !sd_r ##1 1'b1 |-> (motor_phase_out_o & ~$past(oe_r)) == ($past(latch_r) & ~$past(oe_r));
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("disabled phase not from latch");
   property p_force;
      sd_r |=> motor_phase_out_o == $past(latch_r);
   endproperty
   a_force: assert property (p_force) else $error("shutdown did not force latch");
   property p_flag;
      cfg_r.shutdown_enable && fault_rise |=> fault_irq_o;
   endproperty
   a_flag: assert property (p_flag) else $error("fault flag not raised");
   property p_latency;
      $rose(fault_ok) && cfg_r.shutdown_enable |-> ##[1:2] shutdown_active_o;
   endproperty
   a_latency: assert property (p_latency) else $error("shutdown too late");
   property p_keep_xfer;
      sd_r && xfer && cfg_r.transfer_trigger_select != mpt_pkg::MODE_WRITE
         |=> active_r == $past(buf_r[cfg_r.expected_position_code]);
   endproperty
   a_keep_xfer: assert property (p_keep_xfer) else $error("transfer stopped in shutdown");
endmodule

// >>> src/mpt_map.svh
// Purpose: Register offsets, field positions and reset values of the pattern trigger block
// Assumes: Byte addresses on a 32-bit classic Wishbone slave
// Notes: Definitions only
`ifndef MPT_MAP_SVH
`define MPT_MAP_SVH
// Register byte offsets
`define MPT_OFF_CTRL 8'h00
`define MPT_OFF_PORT 8'h04
`define MPT_OFF_ACTIVE 8'h08
`define MPT_OFF_STATUS 8'h0c
// Pattern buffers: 8 words from this base, index in address bits 4:2
`define MPT_BUF_BASE_HI 3'h1
// Control word field positions
`define MPT_CTRL_MODE_LSB 0
`define MPT_CTRL_SDEN_BIT 3
`define MPT_CTRL_SDFILT_BIT 4
`define MPT_CTRL_SDLEN_LSB 5
`define MPT_CTRL_FLAG_BIT 7
`define MPT_CTRL_CODE_LSB 8
`define MPT_CTRL_POSFILT_LSB 11
`define MPT_CTRL_POSLEN_LSB 14
// Port word field positions
`define MPT_PORT_OE_LSB 0
`define MPT_PORT_LATCH_LSB 8
// Status word field positions
`define MPT_STAT_POS_LSB 0
`define MPT_STAT_SD_BIT 3
`define MPT_STAT_TRG_LSB 4
`define MPT_STAT_FAULT_BIT 6
// Reset values
`define MPT_RST_CTRL 16'h0000
`define MPT_RST_PORT 16'h0000
`define MPT_RST_PATTERN 12'h000
// Filter length is 2 to the power (select + this)
`define MPT_FILT_MIN_EXP 3'h2
`endif

// >>> src/mpt_pkg.sv
// Purpose: Types shared by the pattern trigger block
// Assumes: Field positions live in mpt_map.svh
// Notes: Nothing here is imported; use mpt_pkg::name
package mpt_pkg;
   // Transfer trigger modes
   typedef enum logic [2:0] {
      MODE_WRITE = 3'b000,
      MODE_UNDERFLOW = 3'b001,
      MODE_POS = 3'b010,
      MODE_POS_AND_UF = 3'b011,
      MODE_POS_OR_UF = 3'b100,
      MODE_OS_POS_OR_UF = 3'b101,
      MODE_OS_POS = 3'b110,
      MODE_OS_POS_AND_UF = 3'b111
   } mpt_mode_t;
   // Trigger sequencer states
   typedef enum logic [1:0] {
      TRG_IDLE = 2'b00,
      TRG_WAIT_UF = 2'b01,
      TRG_DONE = 2'b10
   } mpt_trg_t;
   // Software configuration carried as one group
   typedef struct packed {
      logic [1:0] pos_len;
      logic [2:0] position_filter_enable;
      logic [2:0] expected_position_code;
      logic [1:0] sd_len;
      logic shutdown_filter_enable;
      logic shutdown_enable;
      mpt_mode_t transfer_trigger_select;
   } mpt_cfg_t;
endpackage

// >>> src/mpt_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module mpt_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_r; // Metastable stage
   logic [W-1:0] s2_r; // Settled stage
   // Both stages shift every cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
      end
   end
   assign q_o = s2_r;
endmodule

// >>> src/mpt_filter.sv
// Purpose: Programmable pulse rejection filter, one counter per bit
// Assumes: Inputs already synchronised to clk_i
// Notes: Output follows input only after a stable run of 2^n cycles
`timescale 1ns/1ps
`include "mpt_map.svh"
module mpt_filter #(
   parameter int W = 1,
   parameter int CW = 5,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] in_i,
   input wire logic [W-1:0] en_i,
   input wire logic [1:0] len_i,
   output logic [W-1:0] out_o
);
   logic [W-1:0] flt_r; // Accepted level
   logic [W-1:0] flt_nxt;
   logic [CW-1:0] cnt_r [W]; // Stable-run counters
   logic [CW-1:0] cnt_nxt [W];
   // Last count of an n-bit counter, n from 2 to 5
   function automatic logic [CW-1:0] run_limit(input logic [1:0] sel);
      logic [2:0] n;
      n = `MPT_FILT_MIN_EXP + {1'b0, sel};
      run_limit = CW'((32'h1 << n) - 32'h1);
   endfunction
   // Restart on change, accept on overflow
   always_comb begin
      for (int i = 0; i < W; i++) begin
         flt_nxt[i] = flt_r[i];
         cnt_nxt[i] = '0;
         if (in_i[i] != flt_r[i]) begin
            if (cnt_r[i] == run_limit(len_i)) begin
               flt_nxt[i] = in_i[i];
            end else begin
               cnt_nxt[i] = cnt_r[i] + CW'(1);
            end
         end
      end
   end
   // Register filter state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flt_r <= RST_VAL;
         for (int i = 0; i < W; i++) cnt_r[i] <= '0;
      end else begin
         flt_r <= flt_nxt;
         for (int i = 0; i < W; i++) cnt_r[i] <= cnt_nxt[i];
      end
   end
   // Bypass per bit when the filter is off
   assign out_o = (en_i & flt_r) | (~en_i & in_i);
endmodule

// >>> verification/mpt_plant_model.sv
// Purpose: Hall sensors, fault pin and reload timer model
// Assumes: Timer runs one-shot from each start pulse
// Notes: Bench calls the tasks directly
`timescale 1ns/1ps
module mpt_plant_model #(
   parameter int DLY = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic timer_start_i,
   output logic [2:0] pos_o,
   output logic fault_n_o,
   output logic uf_o
);
   int cnt = 0; // Cycles to underflow
   int hi = 0; // Pulse cycles left
   initial pos_o = 3'h0;
   initial fault_n_o = 1'h1;
   always @(posedge clk_i) begin
      if (rst_i) cnt <= 0;
      else if (timer_start_i) cnt <= DLY;
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) hi <= 4;
      else if (hi > 0) hi <= hi - 1;
   end
   assign uf_o = (hi > 0);
   // Sensors change just after an edge
   task automatic move(input logic [2:0] v);
      @(posedge clk_i);
      pos_o <= v;
   endtask
   task automatic fault(input logic v);
      @(posedge clk_i);
      fault_n_o <= v;
   endtask
   // Lone underflow with no start
   task automatic fire();
      @(posedge clk_i);
      cnt <= 1;
   endtask
endmodule

// >>> verification/tb.sv
// Purpose: Register level test of the pattern trigger block
// Assumes: Plant model drives sensors, fault pin and timer
// Notes: Ack latency is bounded, never assumed
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic cyc = 1'h0, stb = 1'h0, we = 1'h0, lock = 1'h0;
   logic [3:0] sel = 4'hf;
   logic ppg = 1'h0, osc = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, q, rdat;
   logic ack, tstart, flt, uf, irq, sda;
   logic [2:0] pos;
   logic [5:0] ph_o;
   logic [2:0] om [3] = '{3'h6, 3'h7, 3'h5}; // One-shot modes
   logic [2:0] c1 [3] = '{3'h1, 3'h3, 3'h4};
   logic [2:0] c2 [3] = '{3'h2, 3'h5, 3'h7};
   int failures = 0;
   int num_checks = 0;
   int n, lo;
   mpt_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_lock_i(lock), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_ack_o(ack), .wb_dat_o(rdat), .position_sense_in_i(pos),
      .fault_shutdown_in_i(flt), .reload_timer_pulse_out_i(uf), .ppg_i(ppg),
      .osc_stop_i(osc), .timer_start_o(tstart), .motor_phase_out_o(ph_o),
      .fault_irq_o(irq), .shutdown_active_o(sda));
   mpt_plant_model i_prt (.clk_i(clk_i), .rst_i(rst_i), .timer_start_i(tstart),
      .pos_o(pos), .fault_n_o(flt), .uf_o(uf));
   initial forever #12.5 clk_i = ~clk_i;
   // Buffer k content, nibbles k, ~k, k, distinct for each k
   function automatic logic [31:0] bv(input logic [3:0] k);
      return {20'h0, k, ~k, k};
   endfunction
   // Phase level is the high bit of each pair, ppg held low
   function automatic logic [5:0] ph(input logic [31:0] p);
      for (int i = 0; i < 6; i++) ph[i] = p[2 * i + 1];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One classic cycle, held until ack is seen
   task automatic wb(input logic w, input logic k, input logic [7:0] a, input logic [31:0] d);
      int t = 0;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      lock <= k;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack !== 1'h1 && t < 50);
      q = rdat;
      chk(32'(t < 50), 32'h1, "bus ack");
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      lock <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      wb(1'h0, 1'h0, a, 32'h0);
      chk(q, e, m);
   endtask
   // Control word, e is len, filter, enable; flag written 0
   task automatic ctrl(input logic [2:0] m, input logic [2:0] c, input logic [3:0] e);
      wb(1'h1, 1'h0, 8'h00, {21'h0, c, 1'h0, e, m});
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog, tests need about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(8'h00, 32'h0, "ctrl reset");
      rd(8'h04, 32'h0, "port reset");
      rd(8'h08, 32'h0, "active reset");
      for (int k = 0; k < 8; k++) wb(1'h1, 1'h0, 8'h20 + 8'(4 * k), bv(4'(k)));
      wb(1'h1, 1'h0, 8'h04, 32'h2a3f);
      rd(8'h14, 32'h0, "unmapped");
      // Single lane write to buffer 0 must not transfer
      sel <= 4'h1;
      wb(1'h1, 1'h0, 8'h20, 32'hfff);
      sel <= 4'hf;
      rd(8'h20, 32'h0ff, "lane write");
      rd(8'h08, bv(4'h0), "lane no xfer");
      wb(1'h1, 1'h0, 8'h20, bv(4'h0));
      $display("test reset done");
      ctrl(3'h3, 3'h3, 4'h0);
      i_prt.move(3'h3);
      n = 0;
      while (tstart !== 1'h1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n < 8), 32'h1, "timer start");
      rd(8'h08, bv(4'h0), "early transfer");
      repeat (20) @(posedge clk_i);
      rd(8'h08, bv(4'h3), "uf transfer");
      chk(32'(ph_o), 32'(ph(bv(4'h3))), "phases");
      ctrl(3'h4, 3'h5, 4'h0);
      i_prt.fire();
      repeat (6) @(posedge clk_i);
      rd(8'h08, bv(4'h5), "or uf");
      ctrl(3'h4, 3'h6, 4'h0);
      i_prt.move(3'h6);
      repeat (8) @(posedge clk_i);
      rd(8'h08, bv(4'h6), "or match");
      ctrl(3'h1, 3'h7, 4'h0);
      i_prt.fire();
      repeat (6) @(posedge clk_i);
      rd(8'h08, bv(4'h7), "uf mode");
      ctrl(3'h2, 3'h5, 4'h0);
      i_prt.move(3'h5);
      repeat (8) @(posedge clk_i);
      rd(8'h08, bv(4'h5), "pos mode");
      $display("test triggers done");
      for (int i = 0; i < 3; i++) begin
         ctrl(om[i], c1[i], 4'h0);
         i_prt.move(c1[i]);
         repeat (30) @(posedge clk_i);
         rd(8'h08, bv({1'h0, c1[i]}), "first");
         ctrl(om[i], c2[i], 4'h0);
         i_prt.move(c2[i]);
         repeat (30) @(posedge clk_i);
         rd(8'h08, bv({1'h0, c1[i]}), "later");
      end
      $display("test one-shot done");
      // Mode 100, code 2, all position filters on, shortest length
      wb(1'h1, 1'h0, 8'h00, 32'h3a04);
      i_prt.move(3'h2);
      n = 0;
      while (ph_o !== ph(bv(4'h2)) && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n >= 8 && n <= 10), 32'h1, "pos filter delay");
      for (int v = 0; v < 5; v++) begin
         ctrl(3'h4, 3'(v), (v < 4) ? {2'(v), 2'h3} : 4'h1);
         i_prt.fault(1'h0);
         n = 0;
         while (sda !== 1'h1 && n < 99) begin
            @(posedge clk_i);
            n++;
         end
         lo = (v < 4) ? (4 << v) : 1;
         chk(32'(n >= lo && n <= lo + 6), 32'h1, "fault delay");
         chk(32'(irq), 32'h1, "irq");
         i_prt.fire();
         repeat (6) @(posedge clk_i);
         chk(32'(ph_o), 32'h2a, "latch out");
         rd(8'h08, bv(4'(v)), "xfer in shutdown");
         i_prt.fault(1'h1);
         repeat (50) @(posedge clk_i);
         ctrl(3'h4, 3'h6, 4'h0);
         @(posedge clk_i);
         chk(32'(irq), 32'h0, "irq clear");
      end
      wb(1'h0, 1'h1, 8'h00, 32'h0);
      chk(q, 32'h0684, "locked read");
      // Stopped oscillator voids the filtered fault input
      osc <= 1'h1;
      ctrl(3'h4, 3'h6, 4'h3);
      i_prt.fault(1'h0);
      repeat (50) @(posedge clk_i);
      chk(32'(sda), 32'h0, "osc stopped");
      chk(32'(irq), 32'h0, "osc no irq");
      ctrl(3'h4, 3'h6, 4'h0);
      osc <= 1'h0;
      wb(1'h1, 1'h0, 8'h08, 32'hfff);
      i_prt.fault(1'h0);
      repeat (20) @(posedge clk_i);
      chk(32'(sda), 32'h0, "fault disabled");
      chk(32'(ph_o), 32'(ph(bv(4'h4))), "phases kept");
      // Pairs coded 01 follow the waveform input
      ppg <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk(32'(ph_o), 32'h2e, "ppg phases");
      rd(8'h08, bv(4'h4), "active read only");
      $display("test fault done");
      end_of_test();
   end
endmodule
